// [hw/udc_pkg.sv]
// package: command codes, field layout and reset values for the device command block
package udc_pkg;
  // command phase codes carried in byte 2 of the command word
  localparam logic [7:0] CMD_SET_ADDRESS   = 8'hD0;
  localparam logic [7:0] CMD_CONFIGURE     = 8'hD8;
  localparam logic [7:0] CMD_SET_MODE      = 8'hF3;
  // phase codes carried in byte 1 of the command word
  localparam logic [7:0] PHASE_COMMAND     = 8'h05;
  localparam logic [7:0] PHASE_WRITE       = 8'h01;
  localparam logic [7:0] PHASE_READ        = 8'h02;
  // command word byte positions
  localparam int         CW_PHASE_LSB      = 8;
  localparam int         CW_CODE_LSB       = 16;
  // set-address data byte layout
  localparam int         ADDR_MSB          = 6;
  localparam int         ADDR_EN_BIT       = 7;
  // configure data byte layout
  localparam int         CONF_BIT          = 0;
  // mode data byte layout
  localparam int         MODE_CLK_BIT      = 0;
  localparam int         MODE_NAK_LSB      = 1;
  localparam int         MODE_NAK_MSB      = 6;
  localparam int         NAK_TYPES         = 6;
  // endpoint type indices, NAK mode bit = MODE_NAK_LSB + index
  localparam int         EPT_CTRL_IN       = 0;
  localparam int         EPT_CTRL_OUT      = 1;
  localparam int         EPT_INTR_IN       = 2;
  localparam int         EPT_INTR_OUT      = 3;
  localparam int         EPT_BULK_IN       = 4;
  localparam int         EPT_BULK_OUT      = 5;
  // reset values
  localparam logic [6:0] ADDR_RESET        = 7'h00;
  localparam logic       EN_POR_RESET      = 1'b0;
  localparam logic       EN_BUS_RESET      = 1'b1;
  localparam logic       CONF_RESET        = 1'b0;
  localparam logic [6:0] MODE_RESET        = 7'h00;
endpackage : udc_pkg

// [hw/udc_nak_if.sv]
// interface: per endpoint-type transaction events between the command core and the event gate
`timescale 1ns/1ps
interface udc_nak_if;
  logic [5:0] ack_evt;
  logic [5:0] nak_evt;
  logic [5:0] nak_en;
  logic [5:0] irq;
  modport core (output ack_evt, output nak_evt, output nak_en, input irq);
  modport gate (input ack_evt, input nak_evt, input nak_en, output irq);
endinterface : udc_nak_if

// [hw/udc_nak_gate.sv]
// module: turns endpoint transaction events into endpoint interrupt requests per NAK mode
`timescale 1ns/1ps
module udc_nak_gate (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  udc_nak_if.gate   nak
);
  logic [5:0] irq_r;
  logic [5:0] irq_nxt;

  // ==========================================================
  // per type: success always raises, NAK only when its mode bit is set
  genvar g;
  generate
    for (g = 0; g < udc_pkg::NAK_TYPES; g++) begin : g_type
      always_comb begin
        irq_nxt[g] = nak.ack_evt[g] | (nak.nak_evt[g] & nak.nak_en[g]);
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      irq_r <= 6'h00;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign nak.irq = irq_r;
endmodule : udc_nak_gate

// [hw/udc_dev_cmd.sv]
// module: device-level command handling (set address, configure, set mode)
`timescale 1ns/1ps
// Operation
// - set-address code D0 takes one written byte: address and enable
// - single set-address waits for control status stage before switching address
// - second set-address in a row applies its own written address at once
// - power-on reset clears the function enable bit
// - bus reset sets address zero, enable one; only endpoint zero answers
// - configure code D8 takes one written byte, bit 0 is configured
// - configured flag gates non-control endpoints; resets to zero
// - control endpoints always respond, configured or not
// - good-link LED asserted when configured and pin function selects it
// - set-mode code F3 takes one byte of mode bits, all zero after power-on reset; bus reset keeps them
// - mode bit 0 holds clock request high so clock never stops
// - mode bits 1,2 let NAKs on control IN/OUT raise interrupts
// - mode bits 3,4 do the same for interrupt IN/OUT endpoints
// - mode bits 5,6 do the same for bulk IN/OUT endpoints
// - commands enter as codes in the command code register
module udc_dev_cmd (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_bus_reset,
  input  wire logic        i_cmd_wr,
  input  wire logic [31:0] i_cmd_code,
  input  wire logic        i_status_done,
  input  wire logic        i_pin_link_sel,
  input  wire logic        i_need_clk,
  input  wire logic [6:0]  i_tok_addr,
  input  wire logic [3:0]  i_tok_ep,
  input  wire logic        i_tok_valid,
  input  wire logic        i_ep_enabled,
  input  wire logic [5:0]  i_ack_evt,
  input  wire logic [5:0]  i_nak_evt,
  output logic             o_cmd_busy,
  output logic [6:0]       o_function_address,
  output logic             o_function_enable,
  output logic             o_configured_flag,
  output logic [6:0]       o_mode,
  output logic             o_usb_need_clk,
  output logic             o_good_link,
  output logic             o_tok_respond,
  output logic [5:0]       o_ep_irq
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_CONF = 4'b0100,
    ST_MODE = 4'b1000
  } udc_state_e;

  udc_state_e  state_r, state_nxt;
  logic [6:0]  addr_r, addr_nxt;
  logic [6:0]  pend_addr_r, pend_addr_nxt;
  logic        pend_en_r, pend_en_nxt;
  logic        pend_r, pend_nxt;
  logic        last_addr_r, last_addr_nxt;
  logic        en_r, en_nxt;
  logic        conf_r, conf_nxt;
  logic [6:0]  mode_r, mode_nxt;
  logic [7:0]  phase;
  logic [7:0]  code;
  logic        is_cmd;
  logic        is_wr;
  logic        busy_r, busy_nxt;
  logic        link_r, link_nxt;

  udc_nak_if nak ();

  // ==========================================================
  // command word decode
  assign phase  = i_cmd_code[udc_pkg::CW_PHASE_LSB +: 8];
  assign code   = i_cmd_code[udc_pkg::CW_CODE_LSB +: 8];
  assign is_cmd = i_cmd_wr && (phase == udc_pkg::PHASE_COMMAND);
  assign is_wr  = i_cmd_wr && (phase == udc_pkg::PHASE_WRITE);

  // ==========================================================
  // command sequencer and settings
  always_comb begin
    state_nxt     = state_r;
    addr_nxt      = addr_r;
    pend_addr_nxt = pend_addr_r;
    pend_en_nxt   = pend_en_r;
    pend_nxt      = pend_r;
    last_addr_nxt = last_addr_r;
    en_nxt        = en_r;
    conf_nxt      = conf_r;
    mode_nxt      = mode_r;
    // status stage of the control transfer commits a pending address
    if (pend_r && i_status_done) begin
      addr_nxt = pend_addr_r;
      en_nxt   = pend_en_r;
      pend_nxt = 1'b0;
    end
    if (is_cmd) begin
      case (code)
        udc_pkg::CMD_SET_ADDRESS: state_nxt = ST_ADDR;
        udc_pkg::CMD_CONFIGURE:   state_nxt = ST_CONF;
        udc_pkg::CMD_SET_MODE:    state_nxt = ST_MODE;
        default: begin
          state_nxt     = ST_IDLE;
          last_addr_nxt = 1'b0;
        end
      endcase
    end else if (is_wr) begin
      state_nxt = ST_IDLE;
      case (state_r)
        ST_ADDR: begin
          if (last_addr_r) begin
            addr_nxt = code[udc_pkg::ADDR_MSB:0];
            en_nxt   = code[udc_pkg::ADDR_EN_BIT];
            pend_nxt = 1'b0;
          end else begin
            pend_addr_nxt = code[udc_pkg::ADDR_MSB:0];
            pend_en_nxt   = code[udc_pkg::ADDR_EN_BIT];
            pend_nxt      = 1'b1;
          end
          last_addr_nxt = ~last_addr_r;
        end
        ST_CONF: begin
          conf_nxt      = code[udc_pkg::CONF_BIT];
          last_addr_nxt = 1'b0;
        end
        ST_MODE: begin
          mode_nxt      = code[udc_pkg::MODE_NAK_MSB:0];
          last_addr_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    if (i_bus_reset) begin
      addr_nxt      = udc_pkg::ADDR_RESET;
      en_nxt        = udc_pkg::EN_BUS_RESET;
      pend_nxt      = 1'b0;
      last_addr_nxt = 1'b0;
      conf_nxt      = udc_pkg::CONF_RESET;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r     <= ST_IDLE;
      addr_r      <= udc_pkg::ADDR_RESET;
      pend_addr_r <= udc_pkg::ADDR_RESET;
      pend_en_r   <= udc_pkg::EN_POR_RESET;
      pend_r      <= 1'b0;
      last_addr_r <= 1'b0;
      en_r        <= udc_pkg::EN_POR_RESET;
      conf_r      <= udc_pkg::CONF_RESET;
      mode_r      <= udc_pkg::MODE_RESET;
    end else begin
      state_r     <= state_nxt;
      addr_r      <= addr_nxt;
      pend_addr_r <= pend_addr_nxt;
      pend_en_r   <= pend_en_nxt;
      pend_r      <= pend_nxt;
      last_addr_r <= last_addr_nxt;
      en_r        <= en_nxt;
      conf_r      <= conf_nxt;
      mode_r      <= mode_nxt;
    end
  end

  // ==========================================================
  // token acceptance: control endpoint always, others only when configured
  always_comb begin
    o_tok_respond = 1'b0;
    if (i_tok_valid && en_r && (i_tok_addr == addr_r)) begin
      if (i_tok_ep == 4'h0) begin
        o_tok_respond = 1'b1;
      end else begin
        o_tok_respond = conf_r && i_ep_enabled;
      end
    end
  end

  // ==========================================================
  // NAK interrupt gating
  assign nak.ack_evt = i_ack_evt;
  assign nak.nak_evt = i_nak_evt;
  assign nak.nak_en  = mode_r[udc_pkg::MODE_NAK_MSB:udc_pkg::MODE_NAK_LSB];

  udc_nak_gate u_gate (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .nak       (nak.gate)
  );

  // ==========================================================
  // registered status outputs
  // busy follows the next state, so it still rises at the command edge
  // the led lags the pin select by one clock, never the configured flag
  always_comb begin
    busy_nxt = (state_nxt != ST_IDLE);
    link_nxt = conf_nxt & i_pin_link_sel;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      busy_r <= 1'b0;
      link_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      link_r <= link_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign o_cmd_busy         = busy_r;
  assign o_function_address = addr_r;
  assign o_function_enable  = en_r;
  assign o_configured_flag  = conf_r;
  assign o_mode             = mode_r;
  assign o_usb_need_clk     = mode_r[udc_pkg::MODE_CLK_BIT] | i_need_clk;
  assign o_good_link        = link_r;
  assign o_ep_irq           = nak.irq;
endmodule : udc_dev_cmd

// [test/udc_dev_cmd_props.sv]
// checker: port-level properties of the device command block
`timescale 1ns/1ps
module udc_dev_cmd_props (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_bus_reset,
  input wire logic        i_cmd_wr,
  input wire logic [31:0] i_cmd_code,
  input wire logic        i_status_done,
  input wire logic        i_pin_link_sel,
  input wire logic        i_need_clk,
  input wire logic [6:0]  i_tok_addr,
  input wire logic [3:0]  i_tok_ep,
  input wire logic        i_tok_valid,
  input wire logic        i_ep_enabled,
  input wire logic [5:0]  i_ack_evt,
  input wire logic [5:0]  i_nak_evt,
  input wire logic        o_cmd_busy,
  input wire logic [6:0]  o_function_address,
  input wire logic        o_function_enable,
  input wire logic        o_configured_flag,
  input wire logic [6:0]  o_mode,
  input wire logic        o_usb_need_clk,
  input wire logic        o_good_link,
  input wire logic        o_tok_respond,
  input wire logic [5:0]  o_ep_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  property p_open; i_cmd_wr && !i_bus_reset && i_cmd_code[15:8] == 8'h05
    && i_cmd_code[23:16] inside {8'hD0, 8'hD8, 8'hF3} |=> o_cmd_busy; endproperty
  a_open: assert property (p_open) else $error("command not opened");
  property p_hold; !i_bus_reset && !i_cmd_wr && !i_status_done
    |=> $stable({o_function_address, o_function_enable, o_configured_flag, o_mode}); endproperty
  a_hold: assert property (p_hold) else $error("setting changed without cause");
  property p_por; $fell(i_reset) |-> !o_function_enable && !o_configured_flag && o_mode == 7'h00; endproperty
  a_por: assert property (p_por) else $error("bad value after reset");
  property p_bus; i_bus_reset |=> o_function_address == 7'h00 && o_function_enable && !o_configured_flag; endproperty
  a_bus: assert property (p_bus) else $error("bad value after bus reset");
  property p_gate; i_tok_valid && i_tok_ep != 4'h0 && !o_configured_flag |-> !o_tok_respond; endproperty
  a_gate: assert property (p_gate) else $error("endpoint answered unconfigured");
  property p_ep; i_tok_valid && i_tok_ep != 4'h0 && !i_ep_enabled |-> !o_tok_respond; endproperty
  a_ep: assert property (p_ep) else $error("disabled endpoint answered");
  property p_ctrl; i_tok_valid && i_tok_ep == 4'h0 && o_function_enable
    && i_tok_addr == o_function_address |-> o_tok_respond; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control endpoint silent");
  property p_led; 1'b1 |=> o_good_link == (o_configured_flag && $past(i_pin_link_sel)); endproperty
  a_led: assert property (p_led) else $error("link led wrong");
  property p_clk; o_usb_need_clk == (o_mode[0] || i_need_clk); endproperty
  a_clk: assert property (p_clk) else $error("clock request wrong");
  property p_irq; 1'b1 |=> o_ep_irq == $past(i_ack_evt | (i_nak_evt & o_mode[6:1])); endproperty
  a_irq: assert property (p_irq) else $error("endpoint irq wrong");
endmodule : udc_dev_cmd_props
bind udc_dev_cmd udc_dev_cmd_props u_props (.*);

// [test/udc_host_model.sv]
// host model: presents tokens on the token decode inputs
`timescale 1ns/1ps
module udc_host_model (
  input  wire logic  i_sys_clk,
  output logic [6:0] o_tok_addr,
  output logic [3:0] o_tok_ep,
  output logic       o_tok_valid
);
  initial begin
    o_tok_addr = 7'h55;
    o_tok_ep = 4'hA;
    o_tok_valid = 1'b0;
  end
  task tok(input logic [6:0] a, input logic [3:0] e);
    @(posedge i_sys_clk) #2;
    o_tok_addr = a;
    o_tok_ep = e;
    o_tok_valid = 1'b1;
  endtask : tok
  // idle lines change so nothing stale looks valid
  task idle();
    @(posedge i_sys_clk) #2;
    o_tok_valid = 1'b0;
    o_tok_addr = ~o_tok_addr;
    o_tok_ep = ~o_tok_ep;
  endtask : idle
endmodule : udc_host_model

// [test/test_usb_device_level_commands.sv]
// bench: device command block driven by commands and host tokens
`timescale 1ns/1ps
module test_usb_device_level_commands;
  logic i_sys_clk = 0, i_reset = 1, i_bus_reset = 0, i_cmd_wr = 0, i_status_done = 0;
  logic i_pin_link_sel = 0, i_need_clk = 0, i_ep_enabled = 1, i_tok_valid;
  logic [31:0] i_cmd_code = 0;
  logic [6:0] i_tok_addr, o_function_address, o_mode;
  logic [3:0] i_tok_ep;
  logic [5:0] i_ack_evt = 0, i_nak_evt = 0, o_ep_irq;
  logic o_cmd_busy, o_function_enable, o_configured_flag, o_usb_need_clk, o_good_link, o_tok_respond;
  int errors = 0, comparisons = 0, cyc = 0;
  // rows: code, data byte, expected {configured, mode}
  logic [23:0] rows [10] = '{24'hD80180, 24'hF30181, 24'hF30282, 24'hF30484, 24'hF30888,
                             24'hF31090, 24'hF320A0, 24'hF340C0, 24'hD80040, 24'hF30000};
  udc_dev_cmd dut (.*);
  udc_host_model host (.i_sys_clk(i_sys_clk), .o_tok_addr(i_tok_addr), .o_tok_ep(i_tok_ep),
                       .o_tok_valid(i_tok_valid));
  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] b, input logic [7:0] ph);
    @(posedge i_sys_clk) #2;
    i_cmd_wr = 1;
    i_cmd_code = {8'h00, b, ph, 8'h00};
    @(posedge i_sys_clk) #2;
    i_cmd_wr = 0;
  endtask : wr
  task cmd(input logic [7:0] c, input logic [7:0] d);
    wr(c, udc_pkg::PHASE_COMMAND);
    wr(d, udc_pkg::PHASE_WRITE);
  endtask : cmd
  task tk(input logic [6:0] a, input logic [3:0] e, input logic exp);
    host.tok(a, e);
    #10 chk("respond", 8'(o_tok_respond), 8'(exp));
    host.idle();
  endtask : tk
  task ev(input logic [5:0] a, input logic [5:0] n, input logic [5:0] exp);
    @(posedge i_sys_clk) #2;
    {i_ack_evt, i_nak_evt} = {a, n};
    @(posedge i_sys_clk) #2;
    {i_ack_evt, i_nak_evt} = 12'h000;
    chk("irq", 8'(o_ep_irq), 8'(exp));
  endtask : ev
  task test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    repeat (10) @(posedge i_sys_clk);
    #2 i_reset = 0;
    chk("por", {o_function_enable, o_configured_flag, o_mode[5:0]}, 8'h00);
    cmd(8'hD0, 8'h85);
    chk("addr_pending", {o_function_enable, o_function_address}, 8'h00);
    @(posedge i_sys_clk) #2 i_status_done = 1;
    @(posedge i_sys_clk) #2 i_status_done = 0;
    chk("addr_status", {o_function_enable, o_function_address}, 8'h85);
    // reserved data bits are always written as zero
    foreach (rows[i]) begin
      wr(rows[i][23:16], udc_pkg::PHASE_COMMAND);
      chk("busy", 8'(o_cmd_busy), 8'h01);
      wr(rows[i][15:8], udc_pkg::PHASE_WRITE);
      chk("conf_mode", {o_configured_flag, o_mode}, rows[i][7:0]);
    end
    cmd(8'hD0, 8'h8A);
    chk("addr_once", {o_function_enable, o_function_address}, 8'h85);
    cmd(8'hD0, 8'h8A);
    chk("addr_twice", {o_function_enable, o_function_address}, 8'h8A);
    tk(7'h0A, 4'h0, 1);
    tk(7'h0A, 4'h1, 0);
    cmd(8'hD8, 8'h01);
    tk(7'h0A, 4'h1, 1);
    i_ep_enabled = 0;
    tk(7'h0A, 4'h1, 0);
    tk(7'h0A, 4'h0, 1);
    i_ep_enabled = 1;
    i_pin_link_sel = 1;
    @(posedge i_sys_clk) #2 chk("led", 8'(o_good_link), 8'h01);
    chk("clk_off", 8'(o_usb_need_clk), 8'h00);
    i_need_clk = 1;
    #1 chk("clk_need", 8'(o_usb_need_clk), 8'h01);
    @(posedge i_sys_clk) #2 i_need_clk = 0;
    cmd(8'hF3, 8'h01);
    chk("clk_on", 8'(o_usb_need_clk), 8'h01);
    for (int k = 0; k < 6; k++) begin
      ev(6'h00, 6'(1 << k), 6'h00);
      ev(6'(1 << k), 6'h00, 6'(1 << k));
    end
    // no out endpoint uses dma here, so its nak bits may be set
    cmd(8'hF3, 8'h7E);
    for (int k = 0; k < 6; k++) ev(6'h00, 6'(1 << k), 6'(1 << k));
    @(posedge i_sys_clk) #2 i_bus_reset = 1;
    @(posedge i_sys_clk) #2 i_bus_reset = 0;
    chk("bus_reset", {o_function_enable, o_function_address}, 8'h80);
    chk("bus_conf", {o_configured_flag, o_mode}, 8'h7E);
    chk("led_off", 8'(o_good_link), 8'h00);
    tk(7'h0A, 4'h0, 0);
    tk(7'h00, 4'h0, 1);
    wr(8'h01, udc_pkg::PHASE_WRITE);
    chk("stray_data", {o_configured_flag, o_mode}, 8'h7E);
    wr(8'hF5, udc_pkg::PHASE_COMMAND);
    chk("other_cmd", 8'(o_cmd_busy), 8'h00);
    @(posedge i_sys_clk) #2 i_reset = 1;
    @(posedge i_sys_clk) #2 i_reset = 0;
    chk("por_again", {o_function_enable, o_function_address}, 8'h00);
    chk("por_conf", {o_configured_flag, o_mode}, 8'h00);
    tk(7'h00, 4'h0, 0);
    test_done();
  end
endmodule : test_usb_device_level_commands
